//--- core/icl_pkg.sv
// Constants for the input current limit register bank
package icl_pkg;
	// ==========================================================
	// Command codes
	localparam logic [7:0] ICL_CMD_EFFECTIVE = 8'h22;
	localparam logic [7:0] ICL_CMD_HOST = 8'h3F;
	// ==========================================================
	// Field layout
	localparam int ICL_RSVD_BIT = 15;
	localparam int ICL_FIELD_MSB = 14;
	localparam int ICL_FIELD_LSB = 8;
	localparam int ICL_FIELD_W = 7;
	localparam int ICL_MA_W = 13;
	// ==========================================================
	// Reset values
	localparam logic [15:0] ICL_HOST_RESET = 16'h4100;
	localparam logic [15:0] ICL_EFF_RESET = 16'h4100;
	localparam logic [7:0] ICL_LOW_BYTE = 8'h00;
	localparam logic [15:0] ICL_UNMAPPED_READ = 16'h0000;
	// ==========================================================
	// Current encoding
	localparam logic [12:0] ICL_STEP_MA = 13'h0032;
	localparam logic [12:0] ICL_FLOOR_MA = 13'h0032;
	localparam logic [12:0] ICL_MAX_MA = 13'h1900;
endpackage

//--- core/icl_ma_conv.sv
// Limit code to milliamp converter with registered output
`timescale 1ns/1ps
module icl_ma_conv
	import icl_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [6:0] code,
	output logic [12:0] ma_reg
);
	logic [12:0] ma_next;

	// Code zero still means a small non-zero limit, never a dead input
	always_comb begin
		if (code == 7'h00) begin
			ma_next = ICL_FLOOR_MA;
		end else begin
			ma_next = 13'({6'h00, code} * ICL_STEP_MA);
		end
	end

	// Output register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ma_reg <= 13'(ICL_EFF_RESET[ICL_FIELD_MSB:ICL_FIELD_LSB] * ICL_STEP_MA);
		end else if (clk_en) begin
			ma_reg <= ma_next;
		end
	end
endmodule

//--- core/icl_regs.sv
// Input current limit register bank: host limit and effective limit
`timescale 1ns/1ps
module icl_regs
	import icl_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic adapter_present,
	input wire logic opt_active,
	input wire logic [6:0] opt_code,
	output logic [15:0] rd_data_reg,
	output logic rd_valid_reg,
	output logic wr_invalid_reg,
	output logic [6:0] limit_code_reg,
	output logic [12:0] limit_ma_reg
);
	// ==========================================================
	// Storage
	logic [6:0] host_field_reg;
	logic [6:0] host_field_next;
	logic [6:0] eff_field_next;
	logic adapter_prev_reg;
	logic adapter_removed;
	logic host_wr;
	logic host_wr_ok;
	logic [15:0] host_word;
	logic [15:0] eff_word;

	// Only the field is stored, so reserved bits cannot hold anything
	assign host_word = {1'b0, host_field_reg, ICL_LOW_BYTE};
	assign eff_word = {1'b0, limit_code_reg, ICL_LOW_BYTE};
	assign host_wr = cmd_wr && (cmd_code == ICL_CMD_HOST);
	assign host_wr_ok = host_wr && !cmd_wdata[ICL_RSVD_BIT];
	assign adapter_removed = adapter_prev_reg && !adapter_present;

	// ==========================================================
	// Host limit: removal wins over a write in the same cycle
	always_comb begin
		host_field_next = host_field_reg;
		if (adapter_removed) begin
			host_field_next = ICL_HOST_RESET[ICL_FIELD_MSB:ICL_FIELD_LSB];
		end else if (host_wr_ok) begin
			host_field_next = cmd_wdata[ICL_FIELD_MSB:ICL_FIELD_LSB];
		end
	end

	// Host field register; reset acts even while the core is frozen
	always_ff @(posedge core_clk) begin
		if (srst) begin
			host_field_reg <= ICL_HOST_RESET[ICL_FIELD_MSB:ICL_FIELD_LSB];
		end else if (clk_en) begin
			host_field_reg <= host_field_next;
		end
	end

	// Adapter edge detector; input is already synchronous
	always_ff @(posedge core_clk) begin
		if (srst) begin
			adapter_prev_reg <= 1'b0;
		end else if (clk_en) begin
			adapter_prev_reg <= adapter_present;
		end
	end

	// ==========================================================
	// Effective limit: optimizer result overrides the host value
	always_comb begin
		if (opt_active) begin
			eff_field_next = opt_code;
		end else begin
			eff_field_next = host_field_reg;
		end
	end

	// One cycle behind its sources, traded for a clean register output
	always_ff @(posedge core_clk) begin
		if (srst) begin
			limit_code_reg <= ICL_EFF_RESET[ICL_FIELD_MSB:ICL_FIELD_LSB];
		end else if (clk_en) begin
			limit_code_reg <= eff_field_next;
		end
	end

	// Milliamp value in force, floored at the smallest step
	icl_ma_conv i_icl_ma_conv (
		.core_clk(core_clk),
		.srst(srst),
		.clk_en(clk_en),
		.code(eff_field_next),
		.ma_reg(limit_ma_reg)
	);

	// ==========================================================
	// Read port; unmapped codes read zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_data_reg <= ICL_UNMAPPED_READ;
			rd_valid_reg <= 1'b0;
		end else if (clk_en) begin
			rd_valid_reg <= cmd_rd;
			if (cmd_rd) begin
				case (cmd_code)
					ICL_CMD_HOST: rd_data_reg <= host_word;
					ICL_CMD_EFFECTIVE: rd_data_reg <= eff_word;
					default: rd_data_reg <= ICL_UNMAPPED_READ;
				endcase
			end
		end
	end

	// Invalid write flag pulses for one cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_invalid_reg <= 1'b0;
		end else if (clk_en) begin
			wr_invalid_reg <= host_wr && cmd_wdata[ICL_RSVD_BIT];
		end
	end

	// ==========================================================
	// Assertions: register port
	// Checks look one clock edge after the command is taken, whether or not that edge is enabled
	a_host_reset_val: assert property (@(posedge core_clk) srst |=> host_word == ICL_HOST_RESET)
		else $error("host limit not at reset value");
	a_eff_reset_val: assert property (@(posedge core_clk) srst |=> eff_word == ICL_EFF_RESET)
		else $error("effective limit not at reset value");
	a_invalid_ignored: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && host_wr && cmd_wdata[ICL_RSVD_BIT] && !adapter_removed) |=> wr_invalid_reg && $stable(host_field_reg))
		else $error("invalid write changed host limit");
	a_valid_write_taken: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && host_wr_ok && !adapter_removed)
		|=> host_field_reg == $past(cmd_wdata[ICL_FIELD_MSB:ICL_FIELD_LSB]) && !wr_invalid_reg)
		else $error("valid host write not stored");
	a_low_byte_zero: assert property (@(posedge core_clk) disable iff (srst)
		rd_valid_reg |-> rd_data_reg[7:0] == ICL_LOW_BYTE && rd_data_reg[ICL_RSVD_BIT] == 1'b0)
		else $error("reserved read bits not zero");
	a_invalid_pulse: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && !(host_wr && cmd_wdata[ICL_RSVD_BIT])) |=> !wr_invalid_reg)
		else $error("invalid write flag without invalid write");
	a_ro_write_ignored: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && cmd_wr && cmd_code != ICL_CMD_HOST && !adapter_removed)
		|=> $stable(host_field_reg) && !wr_invalid_reg)
		else $error("write to other code changed host limit");
	a_host_read: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && cmd_rd && cmd_code == ICL_CMD_HOST)
		|=> rd_valid_reg && rd_data_reg == {1'b0, $past(host_field_reg), ICL_LOW_BYTE})
		else $error("host read wrong");
	a_rd_valid_pulse: assert property (@(posedge core_clk) disable iff (srst)
		clk_en |=> rd_valid_reg == $past(cmd_rd))
		else $error("read valid not one cycle after read");
	a_eff_read: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && cmd_rd && cmd_code == ICL_CMD_EFFECTIVE)
		|=> rd_valid_reg && rd_data_reg[ICL_FIELD_MSB:ICL_FIELD_LSB] == $past(limit_code_reg))
		else $error("effective read wrong");

	// ==========================================================
	// Assertions: limit in force
	// The effective word lags its source by one enabled edge
	a_adapter_restore: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && adapter_removed) |=> host_word == ICL_HOST_RESET)
		else $error("adapter removal did not restore limit");
	a_host_copied: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && host_wr_ok && !adapter_removed && !opt_active) ##1 (clk_en && !opt_active)
		|=> limit_code_reg == $past(cmd_wdata[ICL_FIELD_MSB:ICL_FIELD_LSB], 2))
		else $error("host value not copied to effective limit");
	a_eff_tracks_host: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && !opt_active) |=> limit_code_reg == $past(host_field_reg))
		else $error("effective limit does not follow host");
	a_opt_exposed: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && opt_active) |=> limit_code_reg == $past(opt_code))
		else $error("optimizer limit not exposed");
	a_ma_floor: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && eff_field_next == 7'h00) |=> limit_ma_reg == ICL_FLOOR_MA)
		else $error("code zero not floor current");
	a_ma_scale: assert property (@(posedge core_clk) disable iff (srst)
		(clk_en && eff_field_next != 7'h00) |=> limit_ma_reg == 13'($past(eff_field_next)) * ICL_STEP_MA)
		else $error("milliamp scale wrong");
	a_ma_follows_code: assert property (@(posedge core_clk) disable iff (srst)
		limit_ma_reg == ((limit_code_reg == 7'h00) ? ICL_FLOOR_MA : 13'(limit_code_reg) * ICL_STEP_MA))
		else $error("milliamp value and code disagree");
	a_ma_range: assert property (@(posedge core_clk) disable iff (srst)
		limit_ma_reg >= ICL_FLOOR_MA && limit_ma_reg <= ICL_MAX_MA)
		else $error("limit outside span");

	// ==========================================================
	// Assertions: clock enable and reset
	// Reset overrides the enable, so a frozen core may still be reset
	a_freeze: assert property (@(posedge core_clk) disable iff (srst)
		!clk_en |=> $stable(limit_code_reg) && $stable(host_field_reg))
		else $error("state moved while clock enable low");
	a_freeze_outputs: assert property (@(posedge core_clk) disable iff (srst)
		!clk_en |=> $stable(rd_data_reg) && $stable(rd_valid_reg)
		&& $stable(wr_invalid_reg) && $stable(limit_ma_reg))
		else $error("outputs moved while clock enable low");
	a_reset_outputs: assert property (@(posedge core_clk) srst |=> !rd_valid_reg && !wr_invalid_reg
		&& rd_data_reg == ICL_UNMAPPED_READ
		&& limit_ma_reg == 13'(ICL_EFF_RESET[ICL_FIELD_MSB:ICL_FIELD_LSB] * ICL_STEP_MA))
		else $error("outputs not at reset value");

	// ==========================================================
	// Cover points
	c_valid_write: cover property (@(posedge core_clk) disable iff (srst) clk_en && host_wr_ok);
	c_invalid_write: cover property (@(posedge core_clk) disable iff (srst) wr_invalid_reg);
	c_removal: cover property (@(posedge core_clk) disable iff (srst) clk_en && adapter_removed);
	c_opt_override: cover property (@(posedge core_clk) disable iff (srst)
		clk_en && opt_active && opt_code != host_field_reg);
	c_frozen_write: cover property (@(posedge core_clk) disable iff (srst) !clk_en && cmd_wr);
endmodule

//--- tb/icl_host_model.sv
// Host stand-in that drives the command port of the limit registers
`timescale 1ns/1ps
module icl_host_model (
	input wire logic core_clk,
	output logic cmd_wr,
	output logic cmd_rd,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	input wire logic [15:0] rd_data_reg,
	input wire logic rd_valid_reg,
	input wire logic wr_invalid_reg
);
	// ==========================================================
	// Idle bus; data never keeps a stale word after a write
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'hA5A5;
	end
	// One write word; flag is the invalid-write answer one cycle later
	task wr(input logic [7:0] c, input logic [15:0] d, output logic f);
		@(posedge core_clk);
		#1;
		cmd_wr = 1'b1;
		cmd_code = c;
		cmd_wdata = d;
		@(posedge core_clk);
		#1;
		cmd_wr = 1'b0;
		cmd_wdata = ~d;
		f = wr_invalid_reg;
	endtask
	// One read word; data is taken while the valid pulse stands
	task rd(input logic [7:0] c, output logic [15:0] d, output logic v);
		@(posedge core_clk);
		#1;
		cmd_rd = 1'b1;
		cmd_code = c;
		@(posedge core_clk);
		#1;
		cmd_rd = 1'b0;
		d = rd_data_reg;
		v = rd_valid_reg;
	endtask
endmodule

//--- tb/tb_icl_regs.sv
// Self-checking bench for the input current limit registers
`timescale 1ns/1ps
module tb_icl_regs;
	import icl_pkg::*;
	logic core_clk, srst, clk_en, adapter_present, opt_active, cmd_wr, cmd_rd, wr_invalid_reg, rd_valid_reg, f, v;
	logic [6:0] opt_code, limit_code_reg, oc;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, rd_data_reg, hv, d, r;
	logic [12:0] limit_ma_reg;
	int error_cnt = 0, n_compared = 0, seed = 3, cyc = 0;
	// ==========================================================
	// Clock and instances
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	icl_regs i_icl_regs (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .adapter_present(adapter_present), .opt_active(opt_active),
		.opt_code(opt_code), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
		.wr_invalid_reg(wr_invalid_reg), .limit_code_reg(limit_code_reg), .limit_ma_reg(limit_ma_reg));
	icl_host_model i_icl_host_model (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
		.wr_invalid_reg(wr_invalid_reg));
	// ==========================================================
	// Expectations: code zero still means the floor current
	function logic [12:0] ma(input logic [6:0] c);
		return (c == 7'h00) ? ICL_FLOOR_MA : 13'(c) * ICL_STEP_MA;
	endfunction
	function logic [15:0] word(input logic [6:0] c);
		return {1'b0, c, 8'h00};
	endfunction
	// Compare and count
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task complete_run();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Hang guard; the whole sequence needs well under 1000 cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			complete_run();
		end
	end
	// ==========================================================
	// Main sequence: reset values, corner and random words, removal
	initial begin
		srst = 1'b1;
		clk_en = 1'b1;
		adapter_present = 1'b1;
		opt_active = 1'b0;
		opt_code = 7'h00;
		hv = ICL_HOST_RESET;
		repeat (2) @(posedge core_clk);
		#1;
		srst = 1'b0;
		chk(limit_ma_reg, ma(ICL_EFF_RESET[ICL_FIELD_MSB:ICL_FIELD_LSB]));
		i_icl_host_model.rd(ICL_CMD_HOST, r, v);
		chk(r, 16'h4100);
		i_icl_host_model.rd(ICL_CMD_EFFECTIVE, r, v);
		chk(r, 16'h4100);
		chk(v, 1'b1);
		for (int i = 0; i < 24; i++) begin
			d = (i == 0) ? 16'h0000 : (i == 1) ? 16'h7FFF : (i == 2) ? 16'h80FF : 16'($random(seed));
			oc = (i == 3) ? 7'h00 : 7'($random(seed));
			opt_code = oc;
			// Pass 3 forces an optimizer code of zero into force
			opt_active = (i == 3) || ((i > 2) && ($random(seed) & 1));
			// Writes to the read-only word must leave it alone
			if (i % 5 == 4) begin
				i_icl_host_model.wr(ICL_CMD_EFFECTIVE, ~d, f);
			end
			i_icl_host_model.wr(ICL_CMD_HOST, d, f);
			chk(f, d[15]);
			if (!d[15]) begin
				hv = word(d[14:8]);
			end
			i_icl_host_model.rd(ICL_CMD_HOST, r, v);
			chk(r, hv);
			i_icl_host_model.rd(ICL_CMD_EFFECTIVE, r, v);
			chk(r, opt_active ? word(oc) : hv);
			chk(limit_ma_reg, ma(opt_active ? oc : hv[14:8]));
			$display("test %0d done", i);
		end
		i_icl_host_model.rd(8'h10, r, v);
		chk(r, ICL_UNMAPPED_READ);
		// Known non-default value first, so that the restore is visible
		opt_active = 1'b0;
		i_icl_host_model.wr(ICL_CMD_HOST, 16'h0A00, f);
		i_icl_host_model.rd(ICL_CMD_HOST, r, v);
		chk(r, 16'h0A00);
		@(posedge core_clk);
		#1;
		adapter_present = 1'b0;
		i_icl_host_model.rd(ICL_CMD_HOST, r, v);
		chk(r, 16'h4100);
		hv = ICL_HOST_RESET;
		i_icl_host_model.rd(ICL_CMD_EFFECTIVE, r, v);
		chk(r, hv);
		$display("test removal done");
		// Frozen core: a write and an optimizer change must both be ignored
		clk_en = 1'b0;
		opt_active = 1'b1;
		opt_code = 7'h05;
		i_icl_host_model.wr(ICL_CMD_HOST, 16'h1400, f);
		chk(limit_ma_reg, ma(hv[ICL_FIELD_MSB:ICL_FIELD_LSB]));
		clk_en = 1'b1;
		opt_active = 1'b0;
		i_icl_host_model.rd(ICL_CMD_HOST, r, v);
		chk(r, hv);
		$display("test freeze done");
		// Mid-run reset after a non-default write brings both words back
		i_icl_host_model.wr(ICL_CMD_HOST, 16'h2300, f);
		srst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		srst = 1'b0;
		chk(limit_ma_reg, ma(ICL_EFF_RESET[ICL_FIELD_MSB:ICL_FIELD_LSB]));
		i_icl_host_model.rd(ICL_CMD_HOST, r, v);
		chk(r, ICL_HOST_RESET);
		i_icl_host_model.rd(ICL_CMD_EFFECTIVE, r, v);
		chk(r, ICL_EFF_RESET);
		$display("test reset done");
		complete_run();
	end
endmodule
